// file: hdl/spfm_map.vh
// Register map, field positions, reset values and timing counts of the pin mux
`ifndef SPFM_MAP_VH
`define SPFM_MAP_VH
// Register offsets (byte addresses, one byte register each)
`define SPFM_ADDR_SYS_OPT 4'h0
`define SPFM_ADDR_PORT_DATA 4'h1
`define SPFM_ADDR_PORT_DIR 4'h2
`define SPFM_ADDR_PULL_EN 4'h3
`define SPFM_ADDR_PULL_SEL 4'h4
`define SPFM_ADDR_ALT_EN 4'h5
`define SPFM_ADDR_PIN_STATE 4'h6
`define SPFM_ADDR_STATUS 4'h7
// System options fields
`define SPFM_SYSTEM_OPTIONS_REGISTER_RSTPIN_BIT 0
`define SPFM_SYSTEM_OPTIONS_REGISTER_DBGPIN_BIT 1
// Alternate enable fields
`define SPFM_ALT_CMP_IN0_BIT 0
`define SPFM_ALT_KBD_BIT 1
`define SPFM_ALT_CMP_OUT_BIT 2
`define SPFM_ALT_TIMER_EXTERNAL_CLOCK_BIT 3
// Status fields
`define SPFM_STAT_BGND_BIT 0
`define SPFM_STAT_RSTPIN_BIT 1
`define SPFM_STAT_VPP_BIT 2
// Reset values
`define SPFM_SYSTEM_OPTIONS_REGISTER_RESET 8'h02
`define SPFM_PORT_RESET 8'h00
// Timing
`define SPFM_DBG_BIT_CYCLES 16
`define SPFM_SPEEDUP_CYCLES 1
`define SPFM_CNT_W 5
`endif

// file: hdl/spfm_pin_mux.v
// Shared pin function mux: clocks, reset pin, debug pin and port pin priority
//
// Contract
// RL1: Bus clock runs at exactly half the internal clock source rate, feeds everything; here only fixed clock sync and debug bit timing use it.
// RL2: Fixed clock synchronised to bus clock; must stay below half bus clock.
// RL3: After power-on reset the reset-capable pin is a plain input bit.
// RL4: Setting reset pin enable turns that pin into the active-low reset input.
// RL5: Once in reset function the pin stays there until next power-on reset.
// RL6: With reset function selected, a low on the pin resets the device.
// RL7: Reset pin enable set forces the reset pin pullup on.
// RL8: Debug pin is mode select during reset, debug line right after.
// RL9: Debug pin keeps its pullup while in mode select or debug role.
// RL10: Software clears debug pin enable to use that pin as output only.
// RL11: Mode select high at reset release gives run; low gives background mode.
// RL12: Debug bit time is sixteen bus clock cycles.
// RL13: Debug line is pseudo open drain with brief driven-high speedup pulses.
// RL14: After reset the other pins are high-impedance inputs, pulls off.
// RL15: Higher priority enabled function wins; comparator over keyboard over port.
// RL16: Programming voltage on reset pin disables its pullup and pulldown.
// RL17: Debug pin as port bit is output only, reads give no pin level.
// RL18: Keyboard inputs only wake from stop or wait.
// RL19: Each general pin has software pullup and pulldown control.
// RL20: Power-on reset clears reset pin enable and sets debug pin enable.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "spfm_map.vh"
module spfm_pin_mux
(
   input wire mclk,
   input wire rst_b,
   input wire clk_en,
   input wire por_b,
   input wire [3:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg bus_clk_en,
   output reg fixed_clock_en,
   input wire fixed_clock,
   output reg device_reset_b,
   output reg background_mode,
   input wire low_power_mode,
   output wire keypad_wake,
   input wire comparator_output,
   output wire comparator_plus_input,
   output wire timer_external_clock,
   input wire vpp_present,
   input wire dbg_tx_req,
   input wire dbg_tx_bit,
   output reg dbg_tx_busy,
   output reg dbg_rx_level,
   input wire [5:0] pin_in,
   output reg [5:0] pin_out,
   output reg [5:0] pin_oe,
   output reg [5:0] pin_pullup,
   output reg [5:0] pin_pulldown
);
   localparam [1:0] ST_MODE_SEL = 2'h0;
   localparam [1:0] ST_DEBUG = 2'h1;
   localparam [1:0] ST_PORT = 2'h2;
   localparam integer BIT_LAST_I = `SPFM_DBG_BIT_CYCLES - 1;
   localparam integer HALF_BIT_I = `SPFM_DBG_BIT_CYCLES / 2;
   localparam integer SPEEDUP_I = `SPFM_SPEEDUP_CYCLES;
   localparam [4:0] BIT_LAST = BIT_LAST_I[4:0];
   localparam [4:0] HALF_BIT = HALF_BIT_I[4:0];
   localparam [4:0] SPEEDUP = SPEEDUP_I[4:0];

   reg [7:0] system_options_register_q;
   reg rstpin_lock_q;
   reg [7:0] data_q;
   reg [7:0] dir_q;
   reg [7:0] pull_en_q;
   reg [7:0] pull_sel_q;
   reg [7:0] alt_q;
   reg [5:0] pin_s1_q;
   reg [5:0] pin_s2_q;
   reg fx_s1_q;
   reg fx_s2_q;
   reg fx_last_q;
   reg vpp_s1_q;
   reg vpp_s2_q;
   reg [1:0] dbg_state_q;
   reg [1:0] rst_fsm_q;
   reg [4:0] bit_cnt_q;
   reg tx_bit_q;
   reg [4:0] rel_cnt_q;
   reg rstpin_low_q;

   wire rst_pin_sel;
   wire dbg_pin_sel;
   wire vpp_on;
   reg [7:0] rd_mux;

   // RL5 RL4: latched selection survives software writes until power-on
   assign rst_pin_sel = system_options_register_q[`SPFM_SYSTEM_OPTIONS_REGISTER_RSTPIN_BIT] | rstpin_lock_q;
   assign dbg_pin_sel = (dbg_state_q != ST_PORT);
   assign vpp_on = vpp_s2_q;

   // RL1: bus clock enable toggles every source cycle, giving half rate
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         bus_clk_en <= 1'b0;
      else if (clk_en)
         bus_clk_en <= ~bus_clk_en;
   end

   // RL2: fixed clock edges resynchronised; only one edge per two bus cycles can pass
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fx_s1_q <= 1'b0;
         fx_s2_q <= 1'b0;
         fx_last_q <= 1'b0;
         fixed_clock_en <= 1'b0;
      end
      else if (clk_en)
      begin
         fx_s1_q <= fixed_clock;
         fx_s2_q <= fx_s1_q;
         fixed_clock_en <= 1'b0;
         if (bus_clk_en)
         begin
            fx_last_q <= fx_s2_q;
            fixed_clock_en <= fx_s2_q & ~fx_last_q; // RL2
         end
      end
   end

   // Pin and programming voltage synchronisers
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_s1_q <= 6'h00;
         pin_s2_q <= 6'h00;
         vpp_s1_q <= 1'b0;
         vpp_s2_q <= 1'b0;
      end
      else if (clk_en)
      begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
         vpp_s1_q <= vpp_present;
         vpp_s2_q <= vpp_s1_q;
      end
   end

   // Registers; rst_b is the power-on reset of this block
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         system_options_register_q <= `SPFM_SYSTEM_OPTIONS_REGISTER_RESET; // RL20
         rstpin_lock_q <= 1'b0; // RL3
         data_q <= `SPFM_PORT_RESET;
         dir_q <= `SPFM_PORT_RESET; // RL14
         pull_en_q <= `SPFM_PORT_RESET; // RL14
         pull_sel_q <= `SPFM_PORT_RESET;
         alt_q <= `SPFM_PORT_RESET;
      end
      else if (clk_en)
      begin
         if (system_options_register_q[`SPFM_SYSTEM_OPTIONS_REGISTER_RSTPIN_BIT])
            rstpin_lock_q <= 1'b1; // RL5
         if (reg_wr)
         begin
            if (reg_addr == `SPFM_ADDR_SYS_OPT)
            begin
               system_options_register_q <= reg_wdata;
               // Write of zero cannot release a locked reset pin
               if (rstpin_lock_q | system_options_register_q[`SPFM_SYSTEM_OPTIONS_REGISTER_RSTPIN_BIT])
                  system_options_register_q[`SPFM_SYSTEM_OPTIONS_REGISTER_RSTPIN_BIT] <= 1'b1; // RL5
            end
            else if (reg_addr == `SPFM_ADDR_PORT_DATA)
               data_q <= reg_wdata;
            else if (reg_addr == `SPFM_ADDR_PORT_DIR)
               dir_q <= reg_wdata;
            else if (reg_addr == `SPFM_ADDR_PULL_EN)
               pull_en_q <= reg_wdata; // RL19
            else if (reg_addr == `SPFM_ADDR_PULL_SEL)
               pull_sel_q <= reg_wdata; // RL19
            else if (reg_addr == `SPFM_ADDR_ALT_EN)
               alt_q <= reg_wdata;
         end
      end
   end

   // RL6: external low on the reset pin, synchronised and held for release time
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstpin_low_q <= 1'b0;
         device_reset_b <= 1'b0;
         rel_cnt_q <= 5'h00;
      end
      else if (clk_en)
      begin
         rstpin_low_q <= rst_pin_sel & ~pin_s2_q[2] & ~vpp_on; // RL6
         if (rstpin_low_q)
         begin
            device_reset_b <= 1'b0;
            rel_cnt_q <= 5'h00;
         end
         else if (rel_cnt_q != BIT_LAST)
            rel_cnt_q <= rel_cnt_q + 5'h01;
         else
            device_reset_b <= 1'b1;
      end
   end

   // RL8 RL11: mode select sampled at the first enabled clock edge after device reset has risen
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dbg_state_q <= ST_MODE_SEL;
         background_mode <= 1'b0;
         rst_fsm_q <= 2'h0;
      end
      else if (clk_en)
      begin
         rst_fsm_q <= {rst_fsm_q[0], device_reset_b};
         case (dbg_state_q)
            ST_MODE_SEL:
            begin
               if (device_reset_b)
               begin
                  background_mode <= ~pin_s2_q[3]; // RL11
                  dbg_state_q <= ST_DEBUG; // RL8
               end
            end
            ST_DEBUG:
            begin
               if (!device_reset_b)
                  dbg_state_q <= ST_MODE_SEL;
               else if (!system_options_register_q[`SPFM_SYSTEM_OPTIONS_REGISTER_DBGPIN_BIT])
                  dbg_state_q <= ST_PORT; // RL10
            end
            ST_PORT:
            begin
               if (!device_reset_b)
                  dbg_state_q <= ST_MODE_SEL;
               else if (system_options_register_q[`SPFM_SYSTEM_OPTIONS_REGISTER_DBGPIN_BIT])
                  dbg_state_q <= ST_DEBUG;
            end
            default:
               dbg_state_q <= ST_MODE_SEL;
         endcase
      end
   end

   // RL12 RL13: one debug bit is 16 bus cycles; low drive then short driven-high pulse
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dbg_tx_busy <= 1'b0;
         bit_cnt_q <= 5'h00;
         tx_bit_q <= 1'b1;
         dbg_rx_level <= 1'b1;
      end
      else if (clk_en)
      begin
         dbg_rx_level <= pin_s2_q[3];
         if (!dbg_tx_busy)
         begin
            if (dbg_tx_req && dbg_state_q == ST_DEBUG)
            begin
               dbg_tx_busy <= 1'b1;
               tx_bit_q <= dbg_tx_bit;
               bit_cnt_q <= 5'h00;
            end
         end
         else if (bus_clk_en)
         begin
            if (bit_cnt_q == BIT_LAST)
               dbg_tx_busy <= 1'b0; // RL12
            else
               bit_cnt_q <= bit_cnt_q + 5'h01;
         end
      end
   end

   // Pin drive, priority and pulls
   always @*
   begin
      pin_out = data_q[5:0];
      pin_oe = dir_q[5:0];
      pin_pullup = pull_en_q[5:0] & ~pull_sel_q[5:0]; // RL19
      pin_pulldown = pull_en_q[5:0] & pull_sel_q[5:0];
      // RL15: comparator input outranks keyboard and port on bit zero
      if (alt_q[`SPFM_ALT_CMP_IN0_BIT])
      begin
         pin_oe[0] = 1'b0;
         pin_pullup[0] = 1'b0;
         pin_pulldown[0] = 1'b0;
      end
      else if (alt_q[`SPFM_ALT_KBD_BIT])
         pin_oe[0] = 1'b0; // RL15
      if (alt_q[`SPFM_ALT_KBD_BIT])
      begin
         pin_oe[1] = 1'b0;
         pin_oe[4] = 1'b0;
         pin_oe[5] = 1'b0;
      end
      // Bit two is input only
      pin_oe[2] = 1'b0; // RL3
      if (rst_pin_sel)
      begin
         pin_pullup[2] = 1'b1; // RL7
         pin_pulldown[2] = 1'b0;
      end
      if (vpp_on)
      begin
         pin_pullup[2] = 1'b0; // RL16
         pin_pulldown[2] = 1'b0;
      end
      // Bit three: debug line, else comparator out, else output-only port
      if (dbg_pin_sel)
      begin
         pin_pullup[3] = 1'b1; // RL9
         pin_pulldown[3] = 1'b0;
         pin_out[3] = 1'b0;
         pin_oe[3] = 1'b0;
         if (dbg_tx_busy)
         begin
            // RL13: pseudo open drain; only a brief high speedup drive
            if (!tx_bit_q || bit_cnt_q < HALF_BIT)
               pin_oe[3] = (bit_cnt_q < HALF_BIT) | ~tx_bit_q ? (bit_cnt_q < HALF_BIT || !tx_bit_q) : 1'b0;
            else
               pin_oe[3] = 1'b0;
            if (bit_cnt_q >= HALF_BIT && bit_cnt_q < HALF_BIT + SPEEDUP && tx_bit_q)
            begin
               pin_out[3] = 1'b1; // RL13
               pin_oe[3] = 1'b1;
            end
            if (!tx_bit_q && bit_cnt_q >= BIT_LAST - SPEEDUP + 5'h01)
            begin
               pin_out[3] = 1'b1; // RL13
               pin_oe[3] = 1'b1;
            end
         end
      end
      else if (alt_q[`SPFM_ALT_CMP_OUT_BIT])
      begin
         pin_out[3] = comparator_output;
         pin_oe[3] = 1'b1;
      end
      else
         pin_oe[3] = 1'b1; // RL17
   end

   // RL18: keyboard only gives a wakeup, during stop or wait
   // Comparator input on bit zero hides that pin from the keyboard
   assign keypad_wake = alt_q[`SPFM_ALT_KBD_BIT] & low_power_mode &
      ~((pin_s2_q[0] | alt_q[`SPFM_ALT_CMP_IN0_BIT]) & // RL15
      pin_s2_q[1] & pin_s2_q[2] & pin_s2_q[4] & pin_s2_q[5]); // RL18
   assign comparator_plus_input = alt_q[`SPFM_ALT_CMP_IN0_BIT] & pin_s2_q[0];
   assign timer_external_clock = alt_q[`SPFM_ALT_TIMER_EXTERNAL_CLOCK_BIT] & pin_s2_q[2];

   // Register read mux; data one cycle after strobe
   always @*
   begin
      rd_mux = 8'h00;
      if (reg_addr == `SPFM_ADDR_SYS_OPT)
         rd_mux = system_options_register_q;
      else if (reg_addr == `SPFM_ADDR_PORT_DATA)
         rd_mux = data_q;
      else if (reg_addr == `SPFM_ADDR_PORT_DIR)
         rd_mux = dir_q;
      else if (reg_addr == `SPFM_ADDR_PULL_EN)
         rd_mux = pull_en_q;
      else if (reg_addr == `SPFM_ADDR_PULL_SEL)
         rd_mux = pull_sel_q;
      else if (reg_addr == `SPFM_ADDR_ALT_EN)
         rd_mux = alt_q;
      else if (reg_addr == `SPFM_ADDR_PIN_STATE)
         // RL17: debug pin in port role has no input path
         rd_mux = {2'h0, pin_s2_q[5:4], pin_s2_q[3] & dbg_pin_sel, pin_s2_q[2:0]};
      else if (reg_addr == `SPFM_ADDR_STATUS)
         rd_mux = {5'h00, vpp_on, rst_pin_sel, background_mode};
   end

   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         reg_rdata <= 8'h00;
      else if (clk_en)
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
   end
endmodule // spfm_pin_mux
`default_nettype wire

// file: bench/spfm_pin_mux_assertions.sv
// Port-level checker for the shared pin function mux
`timescale 1ns/100ps
`default_nettype none
`include "spfm_map.vh"
module spfm_chk
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic bus_clk_en,
   input wire logic fixed_clock_en,
   input wire logic device_reset_b,
   input wire logic low_power_mode,
   input wire logic keypad_wake,
   input wire logic vpp_present,
   input wire logic dbg_tx_busy,
   input wire logic [5:0] pin_in,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pin_pullup,
   input wire logic [5:0] pin_pulldown
);
   reg rsten_q;
   reg dbgen_q;
   reg [5:0] bcnt_q;
   wire system_options_register_wr = clk_en && reg_wr && reg_addr == `SPFM_ADDR_SYS_OPT;
   always @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rsten_q <= 1'b0;
         dbgen_q <= 1'b1;
         bcnt_q <= 6'h00;
      end
      else
      begin
         // Sticky: only power-on reset may clear it
         rsten_q <= rsten_q | (system_options_register_wr & reg_wdata[0]);
         if (system_options_register_wr)
            dbgen_q <= reg_wdata[1];
         // Bit time counted in bus clocks, not raw clocks
         bcnt_q <= dbg_tx_busy ? bcnt_q + {5'h00, bus_clk_en} : 6'h00;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   sequence s_vpp_off;
      (!vpp_present)[*4];
   endsequence
   sequence s_vpp_on;
      vpp_present[*4];
   endsequence
   sequence s_pin_low;
      (rsten_q && !pin_in[2])[*5];
   endsequence
   property p_bus;
      clk_en |=> bus_clk_en != $past(bus_clk_en);
   endproperty
   property p_fix;
      // Pulse follows a bus edge; next one at least two bus cycles later
      fixed_clock_en && clk_en |-> !bus_clk_en ##1 (!fixed_clock_en)[*3];
   endproperty
   property p_init;
      $rose(rst_b) |-> pin_oe == 6'h00 && pin_pulldown == 6'h00 && pin_pullup == 6'h08;
   endproperty
   property p_rpu;
      s_vpp_off ##0 rsten_q |-> pin_pullup[2];
   endproperty
   property p_vpp;
      s_vpp_on |-> !pin_pullup[2] && !pin_pulldown[2];
   endproperty
   property p_dpu;
      dbgen_q |-> pin_pullup[3];
   endproperty
   property p_prst;
      s_pin_low |-> !device_reset_b;
   endproperty
   property p_por;
      $rose(rst_b) |-> (!device_reset_b)[*8] ##[1:24] device_reset_b;
   endproperty
   property p_kbd;
      keypad_wake |-> low_power_mode;
   endproperty
   property p_bit;
      $fell(dbg_tx_busy) |-> bcnt_q == 6'h10;
   endproperty
   property p_spd;
      // Speedup lasts one bus cycle, two raw clocks
      dbgen_q && $rose(pin_oe[3] && pin_out[3]) |-> ##2 !(pin_oe[3] && pin_out[3]);
   endproperty
   a_bus: assert property (p_bus) else $error("bus enable stalled");
   a_fix: assert property (p_fix) else $error("fixed clock too fast");
   a_init: assert property (p_init) else $error("pins not idle after reset");
   a_rpu: assert property (p_rpu) else $error("reset pin pullup off");
   a_vpp: assert property (p_vpp) else $error("pulls on under vpp");
   a_dpu: assert property (p_dpu) else $error("debug pin pullup off");
   a_prst: assert property (p_prst) else $error("reset pin ignored");
   a_por: assert property (p_por) else $error("reset release wrong");
   a_kbd: assert property (p_kbd) else $error("wake outside low power");
   a_bit: assert property (p_bit) else $error("debug bit time wrong");
   a_spd: assert property (p_spd) else $error("speedup pulse too long");
endmodule // spfm_chk
bind spfm_pin_mux spfm_chk u_chk
(
   .mclk(mclk),
   .rst_b(rst_b),
   .clk_en(clk_en),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .bus_clk_en(bus_clk_en),
   .fixed_clock_en(fixed_clock_en),
   .device_reset_b(device_reset_b),
   .low_power_mode(low_power_mode),
   .keypad_wake(keypad_wake),
   .vpp_present(vpp_present),
   .dbg_tx_busy(dbg_tx_busy),
   .pin_in(pin_in),
   .pin_out(pin_out),
   .pin_oe(pin_oe),
   .pin_pullup(pin_pullup),
   .pin_pulldown(pin_pulldown)
);
`default_nettype wire

// file: bench/spfm_far_end.sv
// Pads with external reset source and debug host
`timescale 1ns/100ps
`default_nettype none
module spfm_far_end
(
   input wire logic mclk,
   input wire logic [5:0] ext_en,
   input wire logic [5:0] ext_val,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pin_pullup,
   input wire logic [5:0] pin_pulldown,
   output logic [5:0] pin_in
);
   logic tgl_q = 1'b0;
   always @(posedge mclk)
      tgl_q <= ~tgl_q;
   always_comb
      for (int i = 0; i < 6; i++)
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (ext_en[i])
            pin_in[i] = ext_val[i];
         else if (pin_pullup[i] | pin_pulldown[i])
            pin_in[i] = pin_pullup[i];
         else
            // Floating pad: keep it moving so no stale level passes
            pin_in[i] = tgl_q;
endmodule // spfm_far_end
`default_nettype wire

// file: bench/testbench.sv
// Self-checking bench for the shared pin function mux
`timescale 1ns/100ps
`default_nettype none
`include "spfm_map.vh"
module testbench;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic fixed_clock = 1'b0;
   logic low_power_mode = 1'b0;
   logic comparator_output = 1'b0;
   logic vpp_present = 1'b0;
   logic dbg_tx_req = 1'b0;
   logic dbg_tx_bit = 1'b0;
   logic [5:0] ext_en = 6'h37;
   logic [5:0] ext_val = 6'h3F;
   logic [7:0] v;
   logic [7:0] n;
   logic [31:0] seed = 32'h9E51AE93;
   int fail_count = 0;
   int check_count = 0;
   wire [7:0] reg_rdata;
   wire bus_clk_en, fixed_clock_en, device_reset_b, background_mode, keypad_wake;
   wire comparator_plus_input, dbg_tx_busy, dbg_rx_level, timer_external_clock;
   wire [5:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown;
   spfm_pin_mux u_dut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .por_b(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .bus_clk_en(bus_clk_en), .fixed_clock_en(fixed_clock_en),
      .fixed_clock(fixed_clock), .device_reset_b(device_reset_b), .background_mode(background_mode),
      .low_power_mode(low_power_mode), .keypad_wake(keypad_wake), .comparator_output(comparator_output),
      .comparator_plus_input(comparator_plus_input), .timer_external_clock(timer_external_clock),
      .vpp_present(vpp_present),
      .dbg_tx_req(dbg_tx_req), .dbg_tx_bit(dbg_tx_bit), .dbg_tx_busy(dbg_tx_busy),
      .dbg_rx_level(dbg_rx_level), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown));
   spfm_far_end u_far (.mclk(mclk), .ext_en(ext_en), .ext_val(ext_val), .pin_out(pin_out),
      .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .pin_in(pin_in));
   always #20 mclk = ~mclk;
   // Slow enough to respect the half bus clock ceiling
   always
   begin
      repeat (3) @(posedge mclk);
      fixed_clock <= ~fixed_clock;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [5:0] exp_pu(input logic [5:0] en, input logic [5:0] sel);
      return (en & ~sel & 6'h37) | 6'h08;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
         fail_count++;
      if (got !== exp)
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      q = reg_rdata;
   endtask
   task automatic wrap_up;
      $display("checks %0d failures %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #(40 * 6000);
      fail_count++;
      wrap_up;
   end
   initial
   begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (40) @(posedge mclk);
      rd(`SPFM_ADDR_SYS_OPT, v);
      chk(v, `SPFM_SYSTEM_OPTIONS_REGISTER_RESET);
      rd(`SPFM_ADDR_STATUS, v);
      chk(v, 8'h00);
      chk(pin_oe, 8'h00);
      chk(background_mode, 8'h00);
      for (int i = 8; i < 24; i++)
      begin
         seed = xs(seed);
         if (i < 16)
            wr(i[3:0], seed[7:0]);
         if (i < 16)
            rd(i[3:0], v);
         if (i < 16)
            chk(v, 8'h00);
         wr(`SPFM_ADDR_PULL_EN, {2'h0, seed[5:0]});
         comparator_output <= seed[16];
         wr(`SPFM_ADDR_PULL_SEL, {2'h0, seed[13:8]});
         // Sample pulls once the landed write has settled
         @(negedge mclk);
         chk(pin_pullup, exp_pu(seed[5:0], seed[13:8]));
         chk(pin_pulldown & 6'h37, seed[5:0] & seed[13:8] & 6'h37);
      end
      wr(`SPFM_ADDR_ALT_EN, 8'h03);
      low_power_mode <= 1'b1;
      ext_val <= 6'h3E;
      repeat (5) @(posedge mclk);
      chk(comparator_plus_input, 8'h00);
      chk(keypad_wake, 8'h00);
      ext_val <= 6'h2F;
      repeat (5) @(posedge mclk);
      chk(comparator_plus_input, 8'h01);
      chk(keypad_wake, 8'h01);
      low_power_mode <= 1'b0;
      ext_val <= 6'h3F;
      repeat (5) @(posedge mclk);
      chk(keypad_wake, 8'h00);
      wr(`SPFM_ADDR_ALT_EN, 8'h0B);
      @(negedge mclk);
      chk(timer_external_clock, 8'h01);
      for (int b = 0; b < 2; b++)
      begin
         // Known bus clock phase, so the bit spans exactly 32 clocks
         @(negedge mclk);
         if (bus_clk_en)
            @(negedge mclk);
         @(posedge mclk);
         dbg_tx_req <= 1'b1;
         dbg_tx_bit <= b[0];
         @(posedge mclk);
         dbg_tx_req <= 1'b0;
         n = 8'h00;
         repeat (80) @(negedge mclk) n += dbg_tx_busy;
         chk(n, 8'h20);
         chk(dbg_rx_level, 8'h01);
      end
      wr(`SPFM_ADDR_SYS_OPT, 8'h03);
      rd(`SPFM_ADDR_STATUS, v);
      chk(v, 8'h02);
      wr(`SPFM_ADDR_SYS_OPT, 8'h02);
      rd(`SPFM_ADDR_SYS_OPT, v);
      chk(v, 8'h03);
      chk(pin_pullup[2], 8'h01);
      @(posedge mclk);
      ext_val[2] <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(device_reset_b, 8'h00);
      ext_val[2] <= 1'b1;
      repeat (40) @(posedge mclk);
      chk(device_reset_b, 8'h01);
      vpp_present <= 1'b1;
      repeat (6) @(posedge mclk);
      chk({pin_pullup[2], pin_pulldown[2]}, 8'h00);
      rd(`SPFM_ADDR_STATUS, v);
      chk(v, 8'h06);
      wr(`SPFM_ADDR_SYS_OPT, 8'h01);
      vpp_present <= 1'b0;
      wr(`SPFM_ADDR_PORT_DIR, 8'h08);
      wr(`SPFM_ADDR_PORT_DATA, 8'h08);
      repeat (2) @(posedge mclk);
      chk({pin_oe[3], pin_out[3]}, 8'h03);
      rd(`SPFM_ADDR_PIN_STATE, v);
      chk(v & 8'h08, 8'h00);
      wr(`SPFM_ADDR_ALT_EN, 8'h04);
      comparator_output <= 1'b0;
      @(negedge mclk);
      chk({pin_oe[3], pin_out[3]}, 8'h02);
      @(posedge mclk);
      clk_en <= 1'b0;
      @(negedge mclk);
      n = {7'h00, bus_clk_en};
      repeat (3) @(negedge mclk);
      chk(bus_clk_en, n);
      @(posedge mclk);
      clk_en <= 1'b1;
      ext_en[3] <= 1'b1;
      ext_val[3] <= 1'b0;
      rst_b <= 1'b0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (40) @(posedge mclk);
      chk(background_mode, 8'h01);
      rd(`SPFM_ADDR_SYS_OPT, v);
      chk(v, 8'h02);
      ext_en[3] <= 1'b0;
      wrap_up;
   end
endmodule // testbench
`default_nettype wire
